//--- common/spie_defs.svh
// constants for the serial port with its dma feed
`ifndef SPIE_DEFS_SVH
`define SPIE_DEFS_SVH
`define SPIE_DW 8
`define SPIE_NCS 4
`define SPIE_CSW 2
`define SPIE_DIVW 8
`define SPIE_PERFW 16
`define SPIE_FIFO_DEPTH 16
`define SPIE_EDGEW 5
`define SPIE_LAST_EDGE 5'h0F
`define SPIE_EXTRA_LAST 5'h01
`define SPIE_BIT_LAST 3'h7
`define SPIE_NPCS_IDLE 4'hF
`define SPIE_TRANSMIT_REGISTER_EMPTY_RST 1'h1
`define SPIE_DIV_ONE 8'h01
`define SPIE_DIV_ZERO 8'h00
`endif

//--- common/spie_pkg.sv
// types shared by the serial port design
package spie_pkg;
`include "spie_defs.svh"

   typedef logic [`SPIE_DW-1:0] spie_word_t;

   typedef struct packed {
      logic in_use;
      logic hold;
      logic idle_pol;
      logic inv_phase;
      logic [`SPIE_DIVW-1:0] divisor;
   } spie_cs_cfg_t;

   typedef enum logic [1:0] {
      SPIE_IDLE,
      SPIE_EXTRA,
      SPIE_SHIFT,
      SPIE_GAP
   } spie_state_t;

   typedef struct packed {
      spie_state_t st;
      logic en;
      logic transmit_register_empty;
      spie_word_t transmit_data_register;
      spie_word_t tx_sh;
      spie_word_t rx_sh;
      spie_word_t rx_data;
      logic rx_rdy;
      logic [`SPIE_EDGEW-1:0] edge_cnt;
      logic [`SPIE_DIVW-1:0] div_cnt;
      logic [`SPIE_CSW-1:0] cur_cs;
      logic sck;
      logic sck_oe;
      logic mosi;
      logic mosi_oe;
      logic [`SPIE_NCS-1:0] npcs_n;
      logic modf;
      logic stall;
      logic stall_off;
      logic [`SPIE_PERFW-1:0] perf;
      logic miso_m;
      logic miso_s;
      logic nss_m;
      logic nss_s;
      logic rtg_m;
      logic rtg_s;
      logic rtg_d;
      logic atg_m;
      logic atg_s;
      logic atg_d;
      spie_word_t slv_tx;
      logic slv_full;
      logic slv_act;
      logic miso_oe;
      logic busy;
      logic dma_rdy;
   } spie_core_t;

   typedef struct packed {
      logic act_m;
      logic act_s;
      logic [2:0] bitcnt;
      logic [`SPIE_DW-2:0] rx_sh;
      spie_word_t rx_word;
      logic rx_tgl;
      spie_word_t tx_sh;
      logic ack_tgl;
      logic miso;
   } spie_link_t;
endpackage

//--- hw/spie_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module spie_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } spie_fifo_st_t;

   spie_fifo_st_t r_reg, r_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign push = in_valid & ~r_reg.full;
   assign pop = out_ready & ~r_reg.empty;
   assign in_ready = ~r_reg.full;
   assign out_valid = ~r_reg.empty;
   assign out_data = mem[r_reg.rp];

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (pop) begin
         r_next.rp = r_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
      r_next.full = (r_next.cnt == (AW+1)'(DEPTH));
      r_next.empty = (r_next.cnt == '0);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // storage needs no reset; only slots behind the write pointer are read
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[r_reg.wp] <= in_data;
      end
   end
endmodule

//--- hw/spie_top.sv
// serial port core with dma feed, keeping the known defect behaviour
//
// How it works
// - in slave mode clearing enable does nothing; only soft reset stops it
// - mixed divisors with one equal 1, idle-high, phase 0 give extra pulse
// - select 0 hold with mode fault detection on: no transfer starts
// - transmit writes while disabled are dropped and leave empty flag alone
// - disabling the port leaves the transmit empty flag unchanged
// - disabled during dma feed: dma keeps draining words, all lost
// - dma transfer error stalls the transmit handshake until a disable then an enable
// - performance counter clears only at power-on; reset control ignored
`timescale 1ns/1ps
`include "spie_defs.svh"
module spie_top (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic PORT_ENABLE,
   input wire logic SLAVE_MODE,
   input wire logic SOFT_RESET,
   input wire logic MODE_FAULT_DISABLE,
   input wire spie_pkg::spie_cs_cfg_t [`SPIE_NCS-1:0] CS_CFG,
   input wire logic [`SPIE_CSW-1:0] CS_SELECT,
   input wire logic TX_WR_VALID,
   input wire spie_pkg::spie_word_t TX_WR_DATA,
   input wire logic RX_READ,
   input wire logic DMA_VALID,
   input wire spie_pkg::spie_word_t DMA_DATA,
   output logic DMA_READY,
   input wire logic DMA_ERROR,
   input wire logic COUNTER_RESET_CONTROL,
   output logic TX_EMPTY,
   output spie_pkg::spie_word_t RX_DATA,
   output logic RX_READY,
   output logic PORT_ACTIVE,
   output logic BUSY,
   output logic MODE_FAULT,
   output logic DMA_STALLED,
   output logic [`SPIE_PERFW-1:0] PERF_COUNT,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic SCK_I,
   output logic MOSI_O,
   output logic MOSI_OE,
   input wire logic MOSI_I,
   output logic MISO_O,
   output logic MISO_OE,
   input wire logic MISO_I,
   output logic [`SPIE_NCS-1:0] NPCS_N_O,
   input wire logic NSS_N_I
);
   import spie_pkg::*;

   spie_core_t r_reg, r_next, rst_val;
   spie_link_t l_reg, l_next;
   spie_cs_cfg_t cur_cfg;
   spie_cs_cfg_t start_cfg;
   logic f_valid;
   logic f_ready;
   logic f_in_ready;
   spie_word_t f_data;
   logic pop;
   logic any_one;
   logic any_not_one;
   logic extra_pulse;
   logic hang;
   logic rx_edge;
   logic ack_edge;
   logic [`SPIE_DIVW-1:0] half_last;
   logic lead;
   logic [`SPIE_PERFW-1:0] perf_keep;

   // the dma channel's own buffer; a stalled handshake backs up into it
   spie_fifo #(
      .WIDTH(`SPIE_DW),
      .DEPTH(`SPIE_FIFO_DEPTH)
   ) u_dma_buf (
      .clk(MCLK),
      .rst_n(RESET_N),
      .ce(CE),
      .in_valid(DMA_VALID & r_reg.dma_rdy),
      .in_ready(f_in_ready),
      .in_data(DMA_DATA),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   assign cur_cfg = CS_CFG[r_reg.cur_cs];
   assign start_cfg = CS_CFG[CS_SELECT];
   assign hang = CS_CFG[0].hold & ~MODE_FAULT_DISABLE;
   assign rx_edge = r_reg.rtg_s ^ r_reg.rtg_d;
   assign ack_edge = r_reg.atg_s ^ r_reg.atg_d;
   // host write has the transmit slot first; the counter reset control
   // input is left unread on purpose
   assign f_ready = ~r_reg.stall &
                    (~r_reg.en | (r_reg.transmit_register_empty & ~TX_WR_VALID));
   assign pop = f_valid & f_ready;

   always_comb begin
      any_one = 1'b0;
      any_not_one = 1'b0;
      for (int i = 0; i < `SPIE_NCS; i++) begin
         if (CS_CFG[i].in_use) begin
            if (CS_CFG[i].divisor == `SPIE_DIV_ONE) begin
               any_one = 1'b1;
            end else begin
               any_not_one = 1'b1;
            end
         end
      end
      extra_pulse = any_one & any_not_one & start_cfg.idle_pol &
                    ~start_cfg.inv_phase;
   end

   always_comb begin
      rst_val = '0;
      rst_val.st = SPIE_IDLE;
      rst_val.transmit_register_empty = `SPIE_TRANSMIT_REGISTER_EMPTY_RST;
      rst_val.npcs_n = `SPIE_NPCS_IDLE;
   end

   always_comb begin
      r_next = r_reg;
      perf_keep = '0;
      lead = 1'b0;
      // a divisor of zero behaves as one
      half_last = (cur_cfg.divisor == `SPIE_DIV_ZERO) ? `SPIE_DIV_ZERO :
                  cur_cfg.divisor - `SPIE_DIV_ONE;

      // pin and link toggle synchronisers
      r_next.miso_m = MISO_I;
      r_next.miso_s = r_reg.miso_m;
      r_next.nss_m = NSS_N_I;
      r_next.nss_s = r_reg.nss_m;
      r_next.rtg_m = l_reg.rx_tgl;
      r_next.rtg_s = r_reg.rtg_m;
      r_next.rtg_d = r_reg.rtg_s;
      r_next.atg_m = l_reg.ack_tgl;
      r_next.atg_s = r_reg.atg_m;
      r_next.atg_d = r_reg.atg_s;

      // once a slave port runs, a cleared enable cannot stop it
      r_next.en = SLAVE_MODE ? (r_reg.en | PORT_ENABLE) : PORT_ENABLE;
      r_next.slv_act = r_reg.en & SLAVE_MODE;
      r_next.miso_oe = r_reg.slv_act & ~r_reg.nss_s;
      r_next.sck_oe = r_reg.en & ~SLAVE_MODE;
      r_next.mosi_oe = r_reg.en & ~SLAVE_MODE;

      // the transmit empty flag only moves on accepted writes, loads and soft reset;
      // enable changes never touch it
      if (pop) begin
         r_next.perf = r_reg.perf + 1'b1;
         if (r_reg.en) begin
            r_next.transmit_data_register = f_data;
            r_next.transmit_register_empty = 1'b0;
         end
      end
      if (TX_WR_VALID && r_reg.en) begin
         r_next.transmit_data_register = TX_WR_DATA;
         r_next.transmit_register_empty = 1'b0;
      end

      // master state machine
      unique case (r_reg.st)
         SPIE_IDLE: begin
            if (r_reg.en && !SLAVE_MODE && !r_reg.transmit_register_empty && !hang) begin
               r_next.transmit_register_empty = ~(TX_WR_VALID | (pop & r_reg.en));
               r_next.cur_cs = CS_SELECT;
               r_next.npcs_n = `SPIE_NPCS_IDLE;
               r_next.npcs_n[CS_SELECT] = 1'b0;
               r_next.sck = start_cfg.idle_pol;
               r_next.edge_cnt = '0;
               r_next.div_cnt = '0;
               r_next.busy = 1'b1;
               if (start_cfg.inv_phase) begin
                  r_next.mosi = r_reg.transmit_data_register[`SPIE_DW-1];
                  r_next.tx_sh = {r_reg.transmit_data_register[`SPIE_DW-2:0], 1'b0};
               end else begin
                  r_next.tx_sh = r_reg.transmit_data_register;
               end
               r_next.st = extra_pulse ? SPIE_EXTRA : SPIE_SHIFT;
            end
         end
         SPIE_EXTRA: begin
            // stray clock pulse before the real bits, with no data moved
            if (r_reg.div_cnt == half_last) begin
               r_next.div_cnt = '0;
               r_next.sck = ~r_reg.sck;
               r_next.edge_cnt = r_reg.edge_cnt + 1'b1;
               if (r_reg.edge_cnt == `SPIE_EXTRA_LAST) begin
                  r_next.edge_cnt = '0;
                  r_next.st = SPIE_SHIFT;
               end
            end else begin
               r_next.div_cnt = r_reg.div_cnt + 1'b1;
            end
         end
         SPIE_SHIFT: begin
            if (r_reg.div_cnt == half_last) begin
               r_next.div_cnt = '0;
               lead = (r_reg.sck == cur_cfg.idle_pol);
               r_next.sck = ~r_reg.sck;
               if (lead == cur_cfg.inv_phase) begin
                  r_next.rx_sh = {r_reg.rx_sh[`SPIE_DW-2:0], r_reg.miso_s};
               end else begin
                  r_next.mosi = r_reg.tx_sh[`SPIE_DW-1];
                  r_next.tx_sh = {r_reg.tx_sh[`SPIE_DW-2:0], 1'b0};
               end
               r_next.edge_cnt = r_reg.edge_cnt + 1'b1;
               if (r_reg.edge_cnt == `SPIE_LAST_EDGE) begin
                  r_next.st = SPIE_GAP;
               end
            end else begin
               r_next.div_cnt = r_reg.div_cnt + 1'b1;
            end
         end
         SPIE_GAP: begin
            r_next.rx_data = r_reg.rx_sh;
            r_next.rx_rdy = 1'b1;
            r_next.busy = 1'b0;
            if (!cur_cfg.hold) begin
               r_next.npcs_n = `SPIE_NPCS_IDLE;
            end
            r_next.st = SPIE_IDLE;
         end
      endcase

      // slave side: hand words to the link clock and collect received ones
      if (r_reg.slv_act) begin
         if (ack_edge) begin
            r_next.slv_full = 1'b0;
         end
         if (!r_reg.slv_full && !r_reg.transmit_register_empty) begin
            r_next.slv_tx = r_reg.transmit_data_register;
            r_next.slv_full = 1'b1;
            r_next.transmit_register_empty = ~(TX_WR_VALID | (pop & r_reg.en));
         end
      end

      // a read of the received word clears ready; a new word wins
      if (RX_READ) begin
         r_next.rx_rdy = 1'b0;
      end
      if (r_reg.slv_act && rx_edge) begin
         r_next.rx_data = l_reg.rx_word;
         r_next.rx_rdy = 1'b1;
      end
      if (r_reg.st == SPIE_GAP) begin
         r_next.rx_rdy = 1'b1;
      end

      // master sees another master pull its select input low
      if (r_reg.en && !SLAVE_MODE && !MODE_FAULT_DISABLE && !r_reg.nss_s)
      begin
         r_next.modf = 1'b1;
      end

      // stalled handshake clears only after a disable then an enable, or on soft reset
      if (r_reg.stall) begin
         if (!r_reg.en) begin
            r_next.stall_off = 1'b1;
         end else if (r_reg.stall_off) begin
            r_next.stall = 1'b0;
            r_next.stall_off = 1'b0;
         end
      end
      if (DMA_ERROR) begin
         r_next.stall = 1'b1;
         r_next.stall_off = 1'b0;
      end

      // ready drops for a cycle after each taken word, so it never
      // promises a slot that the word just taken has filled
      r_next.dma_rdy = f_in_ready & ~(DMA_VALID & r_reg.dma_rdy);
      if (SOFT_RESET) begin
         perf_keep = r_next.perf;
         r_next = rst_val;
         r_next.perf = perf_keep;
      end
   end

   // the buffer takes a word only on the registered ready, so valid and
   // ready agree on every beat at the cost of half the feed rate
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         r_reg <= rst_val;
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   // link side, clocked by the external serial clock in slave mode;
   // it clears itself while the slave-active level is low
   always_comb begin
      l_next = l_reg;
      l_next.act_m = r_reg.slv_act;
      l_next.act_s = l_reg.act_m;
      if (!l_reg.act_s) begin
         l_next.bitcnt = '0;
         l_next.rx_tgl = 1'b0;
         l_next.ack_tgl = 1'b0;
         l_next.rx_sh = '0;
         l_next.tx_sh = '0;
         l_next.miso = 1'b0;
      end else begin
         l_next.rx_sh = {l_reg.rx_sh[`SPIE_DW-3:0], MOSI_I};
         l_next.bitcnt = l_reg.bitcnt + 1'b1;
         if (l_reg.bitcnt == '0) begin
            // word held stable by the core until this toggle comes back
            l_next.miso = r_reg.slv_tx[`SPIE_DW-1];
            l_next.tx_sh = {r_reg.slv_tx[`SPIE_DW-2:0], 1'b0};
            l_next.ack_tgl = ~l_reg.ack_tgl;
         end else begin
            l_next.miso = l_reg.tx_sh[`SPIE_DW-1];
            l_next.tx_sh = {l_reg.tx_sh[`SPIE_DW-2:0], 1'b0};
         end
         if (l_reg.bitcnt == `SPIE_BIT_LAST) begin
            l_next.rx_word = {l_reg.rx_sh, MOSI_I};
            l_next.rx_tgl = ~l_reg.rx_tgl;
         end
      end
   end

   always_ff @(posedge SCK_I) begin
      l_reg <= l_next;
   end

   assign DMA_READY = r_reg.dma_rdy;
   assign TX_EMPTY = r_reg.transmit_register_empty;
   assign RX_DATA = r_reg.rx_data;
   assign RX_READY = r_reg.rx_rdy;
   assign PORT_ACTIVE = r_reg.en;
   assign BUSY = r_reg.busy;
   assign MODE_FAULT = r_reg.modf;
   assign DMA_STALLED = r_reg.stall;
   assign PERF_COUNT = r_reg.perf;
   assign SCK_O = r_reg.sck;
   assign SCK_OE = r_reg.sck_oe;
   assign MOSI_O = r_reg.mosi;
   assign MOSI_OE = r_reg.mosi_oe;
   assign MISO_O = l_reg.miso;
   assign MISO_OE = r_reg.miso_oe;
   assign NPCS_N_O = r_reg.npcs_n;
endmodule

//--- tb/spie_monitor.sv
// assertion checker watching the serial port core from its ports
`timescale 1ns/1ps
`include "spie_defs.svh"
module spie_monitor (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic SOFT_RESET,
   input wire logic MODE_FAULT_DISABLE,
   input wire spie_pkg::spie_cs_cfg_t [`SPIE_NCS-1:0] CS_CFG,
   input wire logic [`SPIE_CSW-1:0] CS_SELECT,
   input wire logic TX_WR_VALID,
   input wire logic DMA_ERROR,
   input wire logic SLAVE_MODE,
   input wire logic TX_EMPTY,
   input wire logic RX_READY,
   input wire logic PORT_ACTIVE,
   input wire logic BUSY,
   input wire logic DMA_STALLED,
   input wire logic [`SPIE_PERFW-1:0] PERF_COUNT,
   input wire logic SCK_O,
   input wire logic [`SPIE_NCS-1:0] NPCS_N_O
);
   import spie_pkg::*;
   logic sck_reg, busy_reg, xtra_reg, one, other;
   logic [4:0] edges_reg;
   always_comb begin
      one = 1'b0;
      other = 1'b0;
      for (int i = 0; i < `SPIE_NCS; i++) begin
         if (CS_CFG[i].in_use && CS_CFG[i].divisor == `SPIE_DIV_ONE)
            one = 1'b1;
         if (CS_CFG[i].in_use && CS_CFG[i].divisor != `SPIE_DIV_ONE)
            other = 1'b1;
      end
   end
   // the jump to idle level at start is not a clock edge, so skip it
   always_ff @(posedge MCLK) begin
      sck_reg <= SCK_O;
      busy_reg <= BUSY;
      if (!RESET_N || !BUSY)
         edges_reg <= 5'h00;
      else if (busy_reg && SCK_O != sck_reg)
         edges_reg <= edges_reg + 5'h01;
      if (!busy_reg)
         xtra_reg <= one && other && CS_CFG[CS_SELECT].idle_pol
            && !CS_CFG[CS_SELECT].inv_phase;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   chk_write_dropped: assert property (
      TX_WR_VALID && !PORT_ACTIVE && !SOFT_RESET |=> $stable(TX_EMPTY))
      else $error("disabled write changed empty flag");
   chk_disable_keeps: assert property (
      $fell(PORT_ACTIVE) && !SOFT_RESET |=> $stable(TX_EMPTY))
      else $error("disable changed empty flag");
   chk_hold_hang: assert property (
      CS_CFG[0].hold && !MODE_FAULT_DISABLE && !BUSY |=> !BUSY)
      else $error("transfer started in hang setup");
   chk_edge_count: assert property (
      $fell(BUSY) |-> edges_reg == (xtra_reg ? 5'h12 : 5'h10))
      else $error("wrong serial clock edge count");
   chk_error_stall: assert property (
      DMA_ERROR && CE |=> DMA_STALLED)
      else $error("dma error did not stall");
   chk_stall_no_drain: assert property (
      DMA_STALLED |=> $stable(PERF_COUNT))
      else $error("words drained while stalled");
   chk_counter_step: assert property (
      $past(RESET_N) && $changed(PERF_COUNT)
      |-> PERF_COUNT == $past(PERF_COUNT) + 16'h0001)
      else $error("performance counter jumped");
   chk_slave_stays: assert property (
      SLAVE_MODE && PORT_ACTIVE && !SOFT_RESET |=> PORT_ACTIVE)
      else $error("slave port stopped without soft reset");
   chk_soft_reset: assert property (
      SOFT_RESET && CE |=> TX_EMPTY && !BUSY && !RX_READY && !PORT_ACTIVE
      && !DMA_STALLED && NPCS_N_O == `SPIE_NPCS_IDLE)
      else $error("soft reset left state behind");
   cover property ($fell(BUSY) && xtra_reg);
   cover property ($rose(DMA_STALLED));
   cover property (SLAVE_MODE && $rose(RX_READY));
endmodule
bind spie_top spie_monitor mon (.MCLK, .RESET_N, .CE, .SOFT_RESET,
   .MODE_FAULT_DISABLE, .CS_CFG, .CS_SELECT, .TX_WR_VALID, .DMA_ERROR,
   .SLAVE_MODE, .TX_EMPTY, .RX_READY, .PORT_ACTIVE, .BUSY, .DMA_STALLED,
   .PERF_COUNT, .SCK_O, .NPCS_N_O);

//--- tb/spie_peer.sv
// far-side serial device: a selected slave and a link-clock frame master
`timescale 1ns/1ps
module spie_peer (
   input wire logic sck,
   input wire logic mosi,
   input wire logic cs_n,
   output logic miso,
   input wire spie_pkg::spie_word_t reply,
   output spie_pkg::spie_word_t got,
   output logic link_sck,
   output logic link_mosi,
   output logic link_nss_n,
   input wire logic link_miso
);
   import spie_pkg::*;
   int bit_idx;
   initial begin
      miso = 1'b0;
      got = '0;
      link_sck = 1'b0;
      link_mosi = 1'b0;
      link_nss_n = 1'b1;
      // link-side logic has no reset: clock it a few times while deselected
      idle(4);
   end
   task automatic idle(input int k);
      repeat (k) begin
         #24 link_sck = 1'b1;
         #24 link_sck = 1'b0;
      end
   endtask
   always @(negedge cs_n) begin
      bit_idx = 7;
      miso = reply[7];
   end
   always @(posedge sck) if (!cs_n) got = {got[6:0], mosi};
   always @(negedge sck) begin
      if (!cs_n && bit_idx > 0) begin
         bit_idx--;
         miso = reply[bit_idx];
      end
   end
   // released line floats: show the inverse so stale data never matches
   always @(posedge cs_n) miso = ~miso;
   task automatic frame(input spie_word_t d, output spie_word_t r);
      link_nss_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         link_mosi = d[i];
         #12 link_sck = 1'b1;
         #24 link_sck = 1'b0;
         r = {r[6:0], link_miso};
         #12;
      end
      link_nss_n = 1'b1;
      link_mosi = ~link_mosi;
   endtask
endmodule

//--- tb/test_spi_errata_behaviour.sv
// self-checking bench for the serial port core with dma feed
`timescale 1ns/1ps
`include "spie_defs.svh"
module test_spi_errata_behaviour;
   import spie_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, slave = 1'b0, srst = 1'b0;
   logic mfd = 1'b1, tx_v = 1'b0, rx_rd = 1'b0, dv = 1'b0, derr = 1'b0;
   logic crc = 1'b0, ce = 1'b1, dma_rdy, tx_empty, rx_rdy, active, busy;
   logic stalled, sck, mosi, miso_o, miso_i, sck_i, mosi_i, nss_n;
   logic sq, bq, ok;
   logic mf, sck_oe, mosi_oe, miso_oe;
   logic [3:0] npcs;
   logic [1:0] sel = 2'h0;
   logic [15:0] perf, p0;
   spie_word_t tx_d = 8'h00, dd = 8'h00, rx_data, reply = 8'h00, got, r;
   spie_cs_cfg_t [`SPIE_NCS-1:0] cfg = '0;
   int num_errors = 0, n_compared = 0, nedge = 0, n;
   always #2.5 clk = ~clk;
   spie_top uut (.MCLK(clk), .RESET_N(rst_n), .CE(ce), .PORT_ENABLE(en),
      .SLAVE_MODE(slave), .SOFT_RESET(srst), .MODE_FAULT_DISABLE(mfd),
      .CS_CFG(cfg), .CS_SELECT(sel), .TX_WR_VALID(tx_v), .TX_WR_DATA(tx_d),
      .RX_READ(rx_rd), .DMA_VALID(dv), .DMA_DATA(dd), .DMA_READY(dma_rdy),
      .DMA_ERROR(derr), .COUNTER_RESET_CONTROL(crc), .TX_EMPTY(tx_empty),
      .RX_DATA(rx_data), .RX_READY(rx_rdy), .PORT_ACTIVE(active),
      .BUSY(busy), .MODE_FAULT(mf), .DMA_STALLED(stalled), .PERF_COUNT(perf),
      .SCK_O(sck), .SCK_OE(sck_oe), .SCK_I(sck_i), .MOSI_O(mosi),
      .MOSI_OE(mosi_oe), .MOSI_I(mosi_i), .MISO_O(miso_o),
      .MISO_OE(miso_oe), .MISO_I(miso_i),
      .NPCS_N_O(npcs), .NSS_N_I(nss_n));
   spie_peer peer (.sck(sck), .mosi(mosi), .cs_n(npcs[0]), .miso(miso_i),
      .reply(reply), .got(got), .link_sck(sck_i), .link_mosi(mosi_i),
      .link_nss_n(nss_n), .link_miso(miso_o));
   always @(posedge clk) begin
      if (busy === 1'b1 && bq) nedge = nedge + (sck !== sq);
      sq = sck;
      bq = busy === 1'b1;
   end
   task chk(input string nm, input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task end_of_test();
      $display("checks %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // one-cycle strobe: 0 dma error, 1 counter reset, 2 read, 3 soft reset
   task pulse(input int w);
      @(posedge clk);
      {srst, rx_rd, crc, derr} <= 4'h1 << w;
      @(posedge clk);
      {srst, rx_rd, crc, derr} <= 4'h0;
      #1;
   endtask
   task wr(input spie_word_t d);
      @(posedge clk);
      tx_v <= 1'b1;
      tx_d <= d;
      @(posedge clk);
      tx_v <= 1'b0;
      #1;
   endtask
   task done(input int e);
      nedge = 0;
      for (int i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
      for (int i = 0; i < 900 && busy !== 1'b0; i++) tick(1);
      chk("sck edges", 16'(nedge), 16'(e));
   endtask
   task push(input spie_word_t d, output logic acc);
      @(posedge clk);
      dv <= 1'b1;
      dd <= d;
      acc = 1'b0;
      for (int i = 0; i < 20 && !acc; i++) begin
         @(posedge clk);
         acc = dma_rdy === 1'b1;
      end
      dv <= 1'b0;
      #1;
   endtask
   initial begin
      cfg[0] = '{1'b1, 1'b0, 1'b0, 1'b1, 8'h04};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
      chk("empty at reset", tx_empty, `SPIE_TRANSMIT_REGISTER_EMPTY_RST);
      chk("selects at reset", npcs, `SPIE_NPCS_IDLE);
      wr(8'h11);
      tick(4);
      chk("dropped write", tx_empty, 1'b1);
      chk("no start", busy, 1'b0);
      for (int i = 0; i < 3; i++) push(8'(8'h20 + i), ok);
      tick(4);
      chk("lost dma words", perf, 16'h0003);
      chk("empty kept", tx_empty, 1'b1);
      @(posedge clk);
      en <= 1'b1;
      reply = 8'h3c;
      tick(2);
      wr(8'ha5);
      done(16);
      chk("sent word", got, 8'ha5);
      chk("received word", rx_data, 8'h3c);
      chk("receive flag", rx_rdy, 1'b1);
      chk("master pins driven", {sck_oe, mosi_oe}, 2'h3);
      pulse(2);
      chk("receive flag cleared", rx_rdy, 1'b0);
      @(posedge clk);
      cfg[0] <= '{1'b1, 1'b0, 1'b1, 1'b0, 8'h01};
      cfg[1] <= '{1'b1, 1'b0, 1'b0, 1'b1, 8'h04};
      tick(2);
      wr(8'h5a);
      done(18);
      @(posedge clk);
      cfg[1].divisor <= 8'h01;
      tick(2);
      wr(8'h5a);
      done(16);
      @(posedge clk);
      cfg[0] <= '{1'b1, 1'b1, 1'b0, 1'b1, 8'h04};
      cfg[1] <= '0;
      mfd <= 1'b0;
      tick(2);
      wr(8'hc3);
      tick(20);
      chk("hang no start", busy, 1'b0);
      chk("hang word waits", tx_empty, 1'b0);
      // another master pulls our select input low while detection is on
      peer.link_nss_n = 1'b0;
      tick(4);
      chk("mode fault seen", mf, 1'b1);
      peer.link_nss_n = 1'b1;
      @(posedge clk);
      en <= 1'b0;
      tick(4);
      chk("empty kept on disable", tx_empty, 1'b0);
      @(posedge clk);
      en <= 1'b1;
      mfd <= 1'b1;
      done(16);
      pulse(3);
      chk("soft reset disables", active, 1'b0);
      chk("selects released", npcs, `SPIE_NPCS_IDLE);
      chk("mode fault cleared", mf, 1'b0);
      @(posedge clk);
      cfg[0].hold <= 1'b0;
      tick(3);
      pulse(0);
      chk("stalled", stalled, 1'b1);
      p0 = perf;
      n = 0;
      ok = 1'b1;
      while (ok && n < 40) begin
         push(8'(n), ok);
         n += ok;
      end
      chk("buffer filled", 16'(n), 16'h0010);
      chk("handshake refused", dma_rdy, 1'b0);
      chk("no drain", perf, p0);
      @(posedge clk);
      en <= 1'b0;
      tick(3);
      @(posedge clk);
      en <= 1'b1;
      tick(3);
      chk("stall cleared", stalled, 1'b0);
      for (int i = 0; i < 3000 && perf !== 16'(p0 + n); i++) tick(1);
      chk("drained", perf, 16'(p0 + n));
      tick(200);
      p0 = perf;
      pulse(1);
      pulse(3);
      chk("counter kept", perf, p0);
      @(posedge clk);
      slave <= 1'b1;
      tick(3);
      wr(8'h5a);
      @(posedge clk);
      en <= 1'b0;
      tick(4);
      chk("slave ignores disable", active, 1'b1);
      // two deselected link clocks carry the slave-active level across
      peer.idle(2);
      peer.frame(8'h96, r);
      tick(8);
      chk("slave received", rx_data, 8'h96);
      chk("slave flag", rx_rdy, 1'b1);
      chk("slave sent", r, 8'h5a);
      chk("slave pins released", {sck_oe, mosi_oe, miso_oe}, 3'h0);
      pulse(2);
      pulse(3);
      chk("soft reset stops", active, 1'b0);
      chk("flag cleared", rx_rdy, 1'b0);
      chk("empty set", tx_empty, 1'b1);
      end_of_test();
   end
   initial begin
      #100000;
      num_errors++;
      $display("BAD watchdog expected finish seen hang");
      end_of_test();
   end
endmodule
